// ---- hdl/sbu_device.sv ----
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/1ns
// Functional notes
// - baud 1200 to 230400, both ends equal
// - characters carry exactly eight data bits
// - parity none/even/odd, one or two stops
// - seven-bit parity host uses eight no-parity
// - host bytes buffered, forwarded until accepted
// - flow control on: drop rts when full
// - flow control on: raise rts with room
// - flow control off: flush full buffer
// - host should use flow control for bulk
// - command mode: silent, no role, configurable
// - direct command control needs command mode
// - mode resets to command mode
// - keep last peer; hardware reset clears
// - reconnect mode: master, connects at software reset when a peer is known
// - reconnect mode: hidden and not connectable
// - wait mode: slave, last peer only
// - open mode: discoverable, accepts anyone
// - peer address held as 48 bits
module sbu_device (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // host link
  sbu_if.dev               lnk,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // radio side roles
  output logic             master_o,
  output logic             connect_req_o,
  output logic             discoverable_o,
  output logic             connectable_o,
  output logic             peer_only_o
);
  // ****************************************************************
  // configuration
  // ****************************************************************
  logic [3:0]            baud_r;
  sbu_pkg::sbu_par_t     par_r;
  logic                  stop2_r;
  logic                  hwfc_r;
  sbu_pkg::sbu_mode_t    mode_r;
  logic [47:0]           peer_r;
  logic                  peer_ok_r;
  logic                  swrst_r;
  logic                  ovf_r;
  logic                  wb_hit;
  logic                  wr;
  logic                  ctrl_wr;
  logic                  rd_data;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic [7:0]            fifo_out_data;
  logic                  flush;
  logic                  rx_valid_r;
  logic [7:0]            rx_data_r;
  logic                  perr_r;

  assign wb_hit  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr      = wb_hit & wb_we_i;
  assign ctrl_wr = wr & (wb_adr_i == sbu_pkg::REG_CTRL);
  assign rd_data = wb_hit & ~wb_we_i & (wb_adr_i == sbu_pkg::REG_DATA);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      baud_r  <= sbu_pkg::BAUD_DEF;
      par_r   <= sbu_pkg::SBU_PAR_NONE;
      stop2_r <= 1'b0;
      hwfc_r  <= 1'b1;
      mode_r  <= sbu_pkg::SBU_MODE_CMD;
    end
    else if (ctrl_wr)
    begin
      if (wb_sel_i[0] && mode_r == sbu_pkg::SBU_MODE_CMD)   // command mode only
      begin
        baud_r  <= wb_dat_i[sbu_pkg::CTRL_BAUD_LSB +: 4];
        par_r   <= sbu_pkg::sbu_par_t'(wb_dat_i[sbu_pkg::CTRL_PAR_LSB +: 2]);
        stop2_r <= wb_dat_i[sbu_pkg::CTRL_STOP2];
        hwfc_r  <= wb_dat_i[sbu_pkg::CTRL_HWFC];
      end
      if (wb_sel_i[1])
        mode_r <= sbu_pkg::sbu_mode_t'(wb_dat_i[sbu_pkg::CTRL_MODE_LSB +: 2]);
    end
  end

  // last peer: survives software reset, cleared only by hardware reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (ctrl_wr && wb_sel_i[1] && wb_dat_i[sbu_pkg::CTRL_HWRST]))
    begin
      peer_r    <= '0;
      peer_ok_r <= 1'b0;
    end
    else if (wr && wb_adr_i == sbu_pkg::REG_PEER)
    begin
      // link layer reports the peer it has connected to: 32 low then 16 high
      if (wb_sel_i[3])
        peer_r[31:0] <= wb_dat_i;
      else
        peer_r[47:32] <= wb_dat_i[15:0];
    end
    else if (ctrl_wr && wb_sel_i[1] && wb_dat_i[sbu_pkg::CTRL_LINKOK])
      peer_ok_r <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      swrst_r <= 1'b1;
    else
      swrst_r <= ctrl_wr && wb_sel_i[1] && wb_dat_i[sbu_pkg::CTRL_SWRST];
  end

  // ****************************************************************
  // role outputs
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      master_o       <= 1'b0;
      connect_req_o  <= 1'b0;
      discoverable_o <= 1'b0;
      connectable_o  <= 1'b0;
      peer_only_o    <= 1'b0;
    end
    else
    begin
      // command mode: no role, nothing announced
      master_o       <= (mode_r == sbu_pkg::SBU_MODE_RECONNECT);
      connect_req_o  <= swrst_r && peer_ok_r && mode_r == sbu_pkg::SBU_MODE_RECONNECT;
      discoverable_o <= (mode_r == sbu_pkg::SBU_MODE_OPEN);
      connectable_o  <= (mode_r == sbu_pkg::SBU_MODE_OPEN)
                        || (mode_r == sbu_pkg::SBU_MODE_WAIT_LAST && peer_ok_r);
      peer_only_o    <= (mode_r == sbu_pkg::SBU_MODE_WAIT_LAST);
    end
  end

  // ****************************************************************
  // serial receiver from host
  // ****************************************************************
  logic [1:0]              rxd_s_r;
  logic [sbu_pkg::DIV_W-1:0] rdiv_r;
  logic [3:0]              rbit_r;
  logic [8:0]              rsh_r;
  logic                    rbusy_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rxd_s_r <= 2'h3;
    else
      rxd_s_r <= {rxd_s_r[0], lnk.txd};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rbusy_r    <= 1'b0;
      rdiv_r     <= '0;
      rbit_r     <= '0;
      rsh_r      <= '0;
      rx_valid_r <= 1'b0;
      rx_data_r  <= '0;
      perr_r     <= 1'b0;
    end
    else
    begin
      rx_valid_r <= 1'b0;
      if (!rbusy_r)
      begin
        if (!rxd_s_r[1])
        begin
          rbusy_r <= 1'b1;
          rbit_r  <= '0;
          rdiv_r  <= sbu_pkg::sbu_div(baud_r) >> 1;
        end
      end
      else if (rdiv_r != '0)
        rdiv_r <= rdiv_r - 1'b1;
      else
      begin
        rdiv_r <= sbu_pkg::sbu_div(baud_r);
        rbit_r <= rbit_r + 1'b1;
        if (rbit_r == 4'h0 && rxd_s_r[1])
          rbusy_r <= 1'b0;
        else if (rbit_r == ((par_r == sbu_pkg::SBU_PAR_NONE) ? 4'h9 : 4'ha))
        begin
          // stop bit: eight data bits only, second stop not checked
          rbusy_r    <= 1'b0;
          rx_valid_r <= rxd_s_r[1];
          rx_data_r  <= rsh_r[7:0];
          perr_r     <= (par_r != sbu_pkg::SBU_PAR_NONE) &&
                        ((^rsh_r) ^ (par_r == sbu_pkg::SBU_PAR_ODD));
        end
        else if (rbit_r != 4'h0)
          rsh_r <= (par_r == sbu_pkg::SBU_PAR_NONE) ? {1'b0, rxd_s_r[1], rsh_r[7:1]}
                   : (rbit_r == 4'h9) ? {rxd_s_r[1], rsh_r[7:0]}
                   : {1'b0, rxd_s_r[1], rsh_r[7:1]};
      end
    end
  end

  // ****************************************************************
  // transmit buffer and flow control
  // ****************************************************************
  // without flow control a full buffer is emptied, so the new byte still fits
  assign flush = ~hwfc_r & rx_valid_r & ~perr_r & ~fifo_in_ready;

  sbu_fifo #(.WIDTH(sbu_pkg::DATA_BITS), .DEPTH(sbu_pkg::FIFO_DEPTH)) u_buf (
    .clk_i(clk_i), .rst_i(rst_i), .flush_i(flush),
    .in_valid_i(rx_valid_r & ~perr_r), .in_data_i(rx_data_r), .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid), .out_data_o(fifo_out_data),
    .out_ready_i(rd_data));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lnk.rts <= 1'b1;
    else
      lnk.rts <= ~hwfc_r | fifo_in_ready;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ovf_r <= 1'b0;
    else if (flush || (rx_valid_r && !fifo_in_ready && hwfc_r))
      ovf_r <= 1'b1;
    else if (wr && wb_adr_i == sbu_pkg::REG_STATUS)
      ovf_r <= 1'b0;
  end

  // device sends nothing back to host in this block
  assign lnk.rxd = 1'b1;

  // ****************************************************************
  // wishbone answer
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= '0;
      if (wb_hit && !wb_we_i)
        unique case (wb_adr_i)
          sbu_pkg::REG_CTRL:   wb_dat_o <= {22'h0, mode_r, hwfc_r, stop2_r, par_r, baud_r};
          sbu_pkg::REG_STATUS: wb_dat_o <= {27'h0, ovf_r, peer_ok_r, lnk.rts,
                                            fifo_out_valid, fifo_in_ready};
          sbu_pkg::REG_DATA:   wb_dat_o <= {23'h0, fifo_out_valid, fifo_out_data};
          sbu_pkg::REG_PEER:   wb_dat_o <= peer_r[31:0];
          default:             wb_dat_o <= '0;
        endcase
    end
  end
endmodule // sbu_device

// ---- hdl/sbu_fifo.sv ----
`timescale 1ns/1ns
module sbu_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             flush_i,
  // fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // drain side
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  // empty reads give zero, never a stale or unwritten slot
  assign out_data_o  = out_valid_o ? mem[rp_r] : '0;
  assign push        = in_valid_i & (in_ready_o | flush_i);
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[flush_i ? '0 : wp_r] <= in_data_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else if (flush_i)
    begin
      // a flush keeps the word that arrives with it
      wp_r  <= AW'(push);
      rp_r  <= '0;
      cnt_r <= (AW+1)'(push);
    end
    else
    begin
      if (push)
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (pop)
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sbu_fifo

// ---- hdl/sbu_host.sv ----
`timescale 1ns/1ns
module sbu_host (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // host link
  sbu_if.host             lnk,
  // framing settings, must match the device
  input  wire logic [3:0] baud_i,
  input  wire logic [1:0] par_i,
  input  wire logic       stop2_i,
  // user byte stream
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o,
  output logic            busy_o
);
  // ****************************************************************
  // transmitter toward the device
  // ****************************************************************
  logic [sbu_pkg::DIV_W-1:0] div_r;
  logic [3:0]                bit_r;
  logic [3:0]                last;
  logic [11:0]               sh_r;
  logic                      par;

  assign par  = (^tx_data_i) ^ (par_i == 2'(sbu_pkg::SBU_PAR_ODD));
  // start, eight data, optional parity, one or two full stop bits
  assign last = 4'ha + 4'(par_i != 2'(sbu_pkg::SBU_PAR_NONE)) + 4'(stop2_i);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_o     <= 1'b0;
      tx_ready_o <= 1'b0;
      lnk.txd    <= 1'b1;
      div_r      <= '0;
      bit_r      <= '0;
      sh_r       <= '1;
    end
    else if (!busy_o)
    begin
      lnk.txd    <= 1'b1;
      tx_ready_o <= lnk.rts & ~tx_ready_o;
      // no new character while rts is low
      if (tx_valid_i && tx_ready_o && lnk.rts)
      begin
        busy_o     <= 1'b1;
        tx_ready_o <= 1'b0;
        bit_r      <= '0;
        div_r      <= sbu_pkg::sbu_div(baud_i);
        lnk.txd    <= 1'b0;
        sh_r       <= (par_i == 2'(sbu_pkg::SBU_PAR_NONE)) ? {3'h7, 1'b1, tx_data_i}
                      : {3'h7, par, tx_data_i};
      end
    end
    else if (div_r != '0)
      div_r <= div_r - 1'b1;
    else
    begin
      div_r <= sbu_pkg::sbu_div(baud_i);
      bit_r <= bit_r + 1'b1;
      if (bit_r + 1'b1 == last)
        busy_o <= 1'b0;
      else
      begin
        lnk.txd <= sh_r[0];
        sh_r    <= {1'b1, sh_r[11:1]};
      end
    end
  end
endmodule // sbu_host

// ---- hdl/sbu_if.sv ----
`timescale 1ns/1ns
interface sbu_if;
  logic txd;        // host to device serial data
  logic rxd;        // device to host serial data
  logic rts;        // device ready for host data, high = go
  modport dev  (input txd, output rxd, output rts);
  modport host (output txd, input rxd, input rts);
endinterface // sbu_if

// ---- hdl/sbu_pkg.sv ----
package sbu_pkg;

  // ****************************************************************
  // clocking and baud
  // ****************************************************************
  localparam int unsigned CLK_HZ    = 25000000;
  localparam int unsigned BAUD_CNT  = 9;
  localparam logic [3:0]  BAUD_DEF  = 4'h7;

  typedef enum logic [1:0] {
    SBU_PAR_NONE,
    SBU_PAR_EVEN,
    SBU_PAR_ODD
  } sbu_par_t;

  typedef enum logic [1:0] {
    SBU_MODE_CMD,
    SBU_MODE_RECONNECT,
    SBU_MODE_WAIT_LAST,
    SBU_MODE_OPEN
  } sbu_mode_t;

  localparam int unsigned DATA_BITS   = 8;
  localparam int unsigned ADDR_BITS   = 48;
  localparam int unsigned FIFO_DEPTH  = 8;
  localparam int unsigned DIV_W       = 16;

  // divisor for one bit time, index 0..8
  function automatic logic [DIV_W-1:0] sbu_div(input logic [3:0] idx);
    logic [31:0] baud;
    baud = 32'h0000_04b0;
    unique case (idx)
      4'h0: baud = 32'h0000_04b0;
      4'h1: baud = 32'h0000_0960;
      4'h2: baud = 32'h0000_12c0;
      4'h3: baud = 32'h0000_2580;
      4'h4: baud = 32'h0000_4b00;
      4'h5: baud = 32'h0000_9538;
      4'h6: baud = 32'h0000_e100;
      4'h7: baud = 32'h0001_c200;
      4'h8: baud = 32'h0003_8400;
      default: baud = 32'h0001_c200;
    endcase
    return DIV_W'(CLK_HZ / baud - 1);
  endfunction

  // ****************************************************************
  // register map of the device controller (wishbone, byte addressed)
  // ****************************************************************
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam logic [3:0] REG_DATA    = 4'h8;
  localparam logic [3:0] REG_PEER    = 4'hc;
  // ctrl fields
  localparam int unsigned CTRL_BAUD_LSB = 0;
  localparam int unsigned CTRL_PAR_LSB  = 4;
  localparam int unsigned CTRL_STOP2    = 6;
  localparam int unsigned CTRL_HWFC     = 7;
  localparam int unsigned CTRL_MODE_LSB = 8;
  localparam int unsigned CTRL_SWRST    = 10;
  localparam int unsigned CTRL_LINKOK   = 11;
  localparam int unsigned CTRL_HWRST    = 12;
endpackage

// ---- verification/sbu_monitor.sv ----
`timescale 1ns/1ns
module sbu_monitor #(
  parameter int unsigned MAX_LOW = 210000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link wires
  input wire logic txd,
  input wire logic rxd,
  input wire logic rts
);
  // ************
  // low-run counter
  // ************
  // a counter instead of a long repetition keeps the tools fast
  logic [31:0] low_cnt_r;
  always_ff @(posedge clk_i)
    if (rst_i || txd)
      low_cnt_r <= 32'h0;
    else
      low_cnt_r <= low_cnt_r + 32'h1;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_reset_line_idle: assert property ($fell(rst_i) |-> txd && rts && rxd)
    else $error("link not idle after reset");
  a_rxd_stays_high: assert property (rxd)
    else $error("device drove its data line");
  a_hold_when_stopped: assert property ((!rts)[*8] |=> !$fell(txd))
    else $error("host started while rts low");
  a_start_min_low: assert property ($fell(txd) |=> (!txd)[*8])
    else $error("low bit too short");
  a_bit_min_high: assert property ($rose(txd) |=> txd[*8])
    else $error("high bit too short");
  a_low_run_bounded: assert property (low_cnt_r < MAX_LOW)
    else $error("line held low too long");
  a_rts_drop_stop: assert property ($fell(rts) |-> txd)
    else $error("rts fell inside a character");
  a_rts_rise_idle: assert property ($rose(rts) |-> txd)
    else $error("rts rose inside a character");
endmodule // sbu_monitor

// ---- verification/tb.sv ----
`timescale 1ns/1ns
module tb;
  // ************
  // signals
  // ************
  typedef struct {
    logic [3:0] baud;
    logic [1:0] dpar;
    logic [1:0] hpar;
    logic       stop2;
    int         rate;
    logic [7:0] data;
    logic       ok;
  } sbu_row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc, wb_stb, wb_we, tx_valid, stop2;
  logic [3:0]  wb_adr, wb_sel, baud, roles;
  logic [1:0]  par;
  logic [7:0]  tx_data;
  logic [31:0] wb_wdat, wb_rdat, rd;
  logic        ack, tx_ready, busy, master, conn_req, disc, conn, peer_only;
  int          per;
  int          fails = 0;
  int          n_compared = 0;
  // {master, discoverable, connectable, peer only} per mode, mask hides free bits
  logic [3:0]  mode_exp [4] = '{4'h0, 4'h8, 4'h3, 4'h6};
  logic [3:0]  mode_msk [4] = '{4'hf, 4'hf, 4'hf, 4'hf};
  // last row: parities disagree, so the byte must be dropped
  sbu_row_t    rows [6] = '{
    '{4'h8, 2'h0, 2'h0, 1'b0, 230400, 8'ha5, 1'b1},
    '{4'h8, 2'h1, 2'h1, 1'b0, 230400, 8'h3c, 1'b1},
    '{4'h8, 2'h2, 2'h2, 1'b1, 230400, 8'h81, 1'b1},
    '{4'h7, 2'h1, 2'h1, 1'b1, 115200, 8'h5a, 1'b1},
    '{4'h4, 2'h0, 2'h0, 1'b0, 19200, 8'h7e, 1'b1},
    '{4'h6, 2'h1, 2'h2, 1'b0, 57600, 8'hc3, 1'b0}};

  assign roles = {master, disc, conn, peer_only};
  always #20 clk_i = ~clk_i;

  sbu_if u_sbu_if ();
  sbu_device u_sbu_device (.clk_i(clk_i), .rst_i(rst_i), .lnk(u_sbu_if.dev),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(ack),
    .master_o(master), .connect_req_o(conn_req), .discoverable_o(disc),
    .connectable_o(conn), .peer_only_o(peer_only));
  sbu_host u_sbu_host (.clk_i(clk_i), .rst_i(rst_i), .lnk(u_sbu_if.host), .baud_i(baud),
    .par_i(par), .stop2_i(stop2), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
    .tx_ready_o(tx_ready), .busy_o(busy));
  sbu_monitor u_sbu_monitor (.clk_i(clk_i), .rst_i(rst_i), .txd(u_sbu_if.txd),
    .rxd(u_sbu_if.rxd), .rts(u_sbu_if.rts));

  // ************
  // tasks
  // ************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [3:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} <= {2'b11, we, a, s, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rd = wb_rdat;
    {wb_cyc, wb_stb} <= 2'b00;
    @(posedge clk_i);
  endtask

  task automatic rdr(input logic [3:0] a);
    wb(1'b0, a, 4'hf, 32'h0);
  endtask

  task automatic send(input logic [7:0] d);
    {tx_valid, tx_data} <= {1'b1, d};
    @(posedge clk_i);
    while (tx_ready !== 1'b1 || u_sbu_if.rts !== 1'b1) @(posedge clk_i);
    tx_valid <= 1'b0;
  endtask

  // samples the wire mid-bit, independent of the receiver
  task automatic cap(input logic [1:0] hp, input logic st2, input logic [7:0] d);
    logic [7:0] b;
    while (u_sbu_if.txd !== 1'b0) @(posedge clk_i);
    repeat (per / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++)
    begin
      repeat (per) @(posedge clk_i);
      b[i] = u_sbu_if.txd;
    end
    check(32'(b), 32'(d));
    if (hp != 2'h0)
    begin
      repeat (per) @(posedge clk_i);
      check(32'(u_sbu_if.txd), 32'(^d ^ (hp == 2'h2)));
    end
    repeat (per) @(posedge clk_i);
    check(32'(u_sbu_if.txd), 32'h1);
    repeat (per * (2 + st2)) @(posedge clk_i);
    check(32'(busy), 32'h0);
  endtask

  task automatic fill(input int n, input int base);
    for (int i = 0; i < n; i++)
    begin
      send(8'(base + i));
      cap(2'h0, 1'b0, 8'(base + i));
    end
  endtask

  task automatic swreset(input logic [1:0] m, output int seen);
    seen = 0;
    fork
      wb(1'b1, sbu_pkg::REG_CTRL, 4'h2, {22'h0, m, 8'h0} | 32'h400);
      repeat (8)
      begin
        @(posedge clk_i);
        seen += int'(conn_req === 1'b1);
      end
    join
  endtask

  // ************
  // sequence
  // ************
  initial
  begin
    repeat (90000) @(posedge clk_i);
    fails++;
    report_and_stop();
  end

  initial
  begin
    int   seen;
    logic lows;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat, tx_valid, tx_data} <= '0;
    {baud, par, stop2} <= {4'h7, 2'h0, 1'b0};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i])
    begin
      wb(1'b1, sbu_pkg::REG_CTRL, 4'h1,
         {24'h0, 1'b1, rows[i].stop2, rows[i].dpar, rows[i].baud});
      {baud, par, stop2} <= {rows[i].baud, rows[i].hpar, rows[i].stop2};
      per = sbu_pkg::CLK_HZ / rows[i].rate;
      send(rows[i].data);
      cap(rows[i].hpar, rows[i].stop2, rows[i].data);
      rdr(sbu_pkg::REG_DATA);
      check(32'(rd[8:0]), rows[i].ok ? 32'h100 | 32'(rows[i].data) : 32'h0);
    end
    wb(1'b1, sbu_pkg::REG_CTRL, 4'h1, 32'h88);
    {baud, par, stop2} <= {4'h8, 2'h0, 1'b0};
    per = sbu_pkg::CLK_HZ / 230400;
    fill(8, 16);
    check(32'(u_sbu_if.rts), 32'h0);
    rdr(sbu_pkg::REG_STATUS);
    check(32'(rd[4:0]), 32'h2);
    lows = 1'b0;
    fork
      send(8'h18);
      begin
        repeat (400)
        begin
          @(posedge clk_i);
          lows = lows | (u_sbu_if.txd === 1'b0);
        end
        check(32'(lows), 32'h0);
        rdr(sbu_pkg::REG_DATA);
        check(32'(rd[8:0]), 32'h110);
        repeat (2) @(posedge clk_i);
        check(32'(u_sbu_if.rts), 32'h1);
      end
    join
    cap(2'h0, 1'b0, 8'h18);
    for (int i = 1; i < 10; i++)
    begin
      rdr(sbu_pkg::REG_DATA);
      check(32'(rd[8:0]), i < 9 ? 32'h100 + 32'(16 + i) : 32'h0);
    end
    wb(1'b1, sbu_pkg::REG_CTRL, 4'h1, 32'h08);
    fill(9, 32);
    check(32'(u_sbu_if.rts), 32'h1);
    rdr(sbu_pkg::REG_STATUS);
    check(32'(rd[4:0]), 32'h17);
    for (int i = 0; i < 2; i++)
    begin
      rdr(sbu_pkg::REG_DATA);
      check(32'(rd[8:0]), i == 0 ? 32'h128 : 32'h0);
    end
    wb(1'b1, sbu_pkg::REG_PEER, 4'hf, 32'h89ab_cdef);
    wb(1'b1, sbu_pkg::REG_PEER, 4'h3, 32'h4567);
    swreset(2'h1, seen);
    check(32'(seen), 32'h0);
    wb(1'b1, sbu_pkg::REG_CTRL, 4'h2, 32'h800);
    rdr(sbu_pkg::REG_STATUS);
    check(32'(rd[3]), 32'h1);
    wb(1'b1, 4'h2, 4'hf, 32'hffff_ffff);
    rdr(sbu_pkg::REG_PEER);
    check(rd, 32'h89ab_cdef);
    for (int m = 3; m >= 0; m--)
    begin
      wb(1'b1, sbu_pkg::REG_CTRL, 4'h2, 32'(m) << 8);
      repeat (2) @(posedge clk_i);
      check(32'(roles & mode_msk[m]), 32'(mode_exp[m]));
      if (m == 3)
      begin
        // settings byte outside command mode must be ignored
        wb(1'b1, sbu_pkg::REG_CTRL, 4'h1, 32'h0);
        rdr(sbu_pkg::REG_CTRL);
        check(32'(rd[9:0]), 32'h308);
      end
    end
    swreset(2'h1, seen);
    check(32'(seen), 32'h1);
    swreset(2'h2, seen);
    check(32'(seen), 32'h0);
    wb(1'b1, sbu_pkg::REG_CTRL, 4'h2, 32'h1100);
    swreset(2'h1, seen);
    check(32'(seen), 32'h0);
    rdr(sbu_pkg::REG_STATUS);
    check(32'(rd[3]), 32'h0);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(32'({roles, u_sbu_if.rts, u_sbu_if.rxd}), 32'h3);
    rdr(sbu_pkg::REG_CTRL);
    check(32'(rd[9:0]), {24'h0, 4'h8, sbu_pkg::BAUD_DEF});
    rdr(sbu_pkg::REG_STATUS);
    check(32'(rd[4:0]), 32'h5);
    report_and_stop();
  end
endmodule // tb
